// ==== hdl/svp_consts.svh ====
// Constants of the sequence voltage protection stage.
// Assumes a 200 MHz clock and a measurement front end that strobes each 5 ms program cycle.
// How it works
// - Positive sequence is one third of L1 plus L2 at 120 plus L3 at 240.
// - Negative sequence is one third of L1 plus L2 at 240 plus L3 at 120.
// - Works on fundamental phasors of three channels, refreshed each 5 ms cycle.
// - Static selection picks positive or negative sequence, positive after reset.
// - Force setting normal/start/trip/blocked overrides status only when forcing enabled.
// - Over mode picks up above level, under mode below level; over is default.
// - Over mode releases only below 97 percent of the pick-up level.
// - Under mode releases only above 103 percent of the pick-up level.
// - Pick-up level in 0.01 percent steps, default 105 percent; ratio reported.
// - Under mode: below blocking level no trip until all line voltages exceed level.
// - Blocking level of zero disables low-voltage blocking.
// - External block input sampled once at the start of each program cycle.
// - Pick-up with block inactive asserts START and starts operate timing.
// - Pick-up with block active asserts BLOCKED and nothing further.
// - Block arriving during START clears START; release timing as for dropout.
// - Expected operating time reported in 5 ms steps, taken from the fixed delay setting.
// - Elapsed operate time and present ratio at 0.01 resolution are reported.
// - Selection and force are static; pick-up settings may change while running.
// - Fixed delay: TRIP after delay while picked up; zero delay trips with START.
// - With delayed release START holds for the release delay after dropout.
// - Four independent stages, each with its own start, trip and block events.
`ifndef SVP_CONSTS_SVH
`define SVP_CONSTS_SVH
`define SVP_CYCLE_MS 5
`define SVP_DLY_DEF 16'h0008
`define SVP_REL_DEF 16'h000C
`define SVP_SET_DEF 16'h2904
`define SVP_BLK_DEF 16'h01F4
`define SVP_HYST_OVER 16'h0061
`define SVP_HYST_UNDER 16'h0067
`define SVP_COS120 18'h3C000
`define SVP_SIN120 18'h06EDA
`define SVP_THIRD 18'h02AAB
`define SVP_ADR_CTRL 8'h00
`define SVP_ADR_SET 8'h04
`define SVP_ADR_BLK 8'h08
`define SVP_ADR_DLY 8'h0C
`define SVP_ADR_REL 8'h10
`define SVP_ADR_STAT 8'h14
`define SVP_ADR_MAG 8'h18
`define SVP_ADR_RATIO 8'h1C
`define SVP_ADR_TIME 8'h20
`define SVP_CTRL_RST 32'h0000_0002
`endif

// ==== hdl/svp_pkg.sv ====
// Types of the sequence voltage protection stage.
// Assumes the constants header is included by the design file.
package svp_pkg;
   typedef enum logic [1:0] {
      SVP_F_NORMAL = 2'b00,
      SVP_F_START = 2'b01,
      SVP_F_TRIP = 2'b10,
      SVP_F_BLOCKED = 2'b11
   } svp_force_t;
   typedef enum logic [1:0] {
      SVP_S_IDLE = 2'b00,
      SVP_S_RUN = 2'b01,
      SVP_S_HOLD = 2'b10,
      SVP_S_BLK = 2'b11
   } svp_state_t;
endpackage

// ==== hdl/svp_stage.sv ====
// Four-stage sequence voltage protection with a classic Wishbone register slave.
// Assumes phasors in Q2.15 of nominal and cycle_tick pulsing once per program cycle.
`timescale 1ns/1ps
`include "svp_consts.svh"
`default_nettype none
module svp_stage
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cycle_tick,
   input wire logic signed [17:0] l1_re,
   input wire logic signed [17:0] l1_im,
   input wire logic signed [17:0] l2_re,
   input wire logic signed [17:0] l2_im,
   input wire logic signed [17:0] l3_re,
   input wire logic signed [17:0] l3_im,
   input wire logic [15:0] line_mag1,
   input wire logic [15:0] line_mag2,
   input wire logic [15:0] line_mag3,
   input wire logic [3:0] block_in,
   input wire logic force_enable,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic [3:0] start_o,
   output logic [3:0] trip_o,
   output logic [3:0] blocked_o
);
   // ==========================================================
   // Types and helpers
   typedef struct packed {
      logic [1:0] rst_sync;
      logic [31:0] ctrl;
      logic [3:0][15:0] set;
      logic [3:0][15:0] blk;
      logic [3:0][15:0] dly;
      logic [3:0][15:0] rel;
      logic [3:0] over;
      logic [3:0] drel;
      logic [3:0] pick;
      logic [3:0] lowblk;
      logic [3:0] ext_blk;
      logic [3:0][15:0] cnt;
      logic [3:0][15:0] rcnt;
      logic [3:0][15:0] ratio;
      svp_pkg::svp_state_t [3:0] st;
      logic [15:0] mag;
      logic [1:0] calc;
      logic [31:0] dat;
      logic ack;
      logic [3:0] start;
      logic [3:0] trip;
      logic [3:0] blocked;
   } svp_state_all_t;

   // Q15 multiply, keeping the signed integer part
   function automatic logic signed [17:0] qmul(input logic signed [17:0] a,
                                               input logic signed [17:0] b);
      logic signed [35:0] p;
      p = a * b;
      qmul = p[32:15];
   endfunction

   // Merge a write under byte enables
   function automatic logic [15:0] bmerge(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
      bmerge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
   endfunction

   // Two-branch max/min magnitude estimate: exact on an axis, within about two percent
   // elsewhere, so the 97 and 103 percent release points are not swamped by its error
   function automatic logic [15:0] amag(input logic signed [17:0] re,
                                        input logic signed [17:0] im);
      logic [17:0] ar;
      logic [17:0] ai;
      logic [17:0] mx;
      logic [17:0] mn;
      logic [17:0] b0;
      logic [17:0] b1;
      ar = re[17] ? 18'(-re) : 18'(re);
      ai = im[17] ? 18'(-im) : 18'(im);
      mx = (ar > ai) ? ar : ai;
      mn = (ar > ai) ? ai : ar;
      b0 = 18'(mx + (mn >> 3) + (mn >> 5));
      b1 = 18'(mx - (mx >> 3) - (mx >> 5) + (mn >> 1) + (mn >> 5) + (mn >> 6) + (mn >> 7));
      amag = 16'((b0 > b1) ? b0 : b1);
   endfunction

   svp_state_all_t q;
   svp_state_all_t d;
   logic rst_n_int;
   assign rst_n_int = q.rst_sync[1];

   // ==========================================================
   // Sequence components, rotation by 120 and 240 degrees
   logic signed [17:0] r2_re, r2_im, r3_re, r3_im, s_re, s_im;
   logic [15:0] lvl_mag;
   always_comb
   begin
      // Negative sequence swaps which phase gets the 120 and 240 rotation
      if (q.ctrl[0])
      begin
         r2_re = 18'(qmul(l2_re, `SVP_COS120) + qmul(l2_im, `SVP_SIN120));
         r2_im = 18'(qmul(l2_im, `SVP_COS120) - qmul(l2_re, `SVP_SIN120));
         r3_re = 18'(qmul(l3_re, `SVP_COS120) - qmul(l3_im, `SVP_SIN120));
         r3_im = 18'(qmul(l3_im, `SVP_COS120) + qmul(l3_re, `SVP_SIN120));
      end
      else
      begin
         r2_re = 18'(qmul(l2_re, `SVP_COS120) - qmul(l2_im, `SVP_SIN120));
         r2_im = 18'(qmul(l2_im, `SVP_COS120) + qmul(l2_re, `SVP_SIN120));
         r3_re = 18'(qmul(l3_re, `SVP_COS120) + qmul(l3_im, `SVP_SIN120));
         r3_im = 18'(qmul(l3_im, `SVP_COS120) - qmul(l3_re, `SVP_SIN120));
      end
      s_re = qmul(18'(l1_re + r2_re + r3_re), `SVP_THIRD);
      s_im = qmul(18'(l1_im + r2_im + r3_im), `SVP_THIRD);
      // Supervised magnitude in 0.01 percent of nominal, Q15 of 1.0 maps to 10000
      lvl_mag = 16'((32'(amag(s_re, s_im)) * 32'd10000) >> 15);
   end

   // ==========================================================
   // Next-state logic
   logic hit;
   logic [15:0] wsel;
   logic [31:0] prod;
   logic [31:0] hyst;
   logic pick_n;
   logic lowblk_n;
   logic trip_n;
   always_comb
   begin
      d = q;
      hit = 1'b0;
      wsel = {14'h0000, wb_adr_i[7:6]};
      prod = 32'h0000_0000;
      hyst = 32'h0000_0000;
      pick_n = 1'b0;
      lowblk_n = 1'b0;
      trip_n = 1'b0;
      d.rst_sync = {q.rst_sync[0], 1'b1};
      d.ack = 1'b0;
      // Classic Wishbone: one wait state, ack drops the cycle after it is given
      hit = wb_cyc_i && wb_stb_i && !q.ack;
      if (hit)
      begin
         d.ack = 1'b1;
         d.dat = 32'h0000_0000;
         case (wb_adr_i & 8'h3C)
            `SVP_ADR_CTRL: d.dat = q.ctrl;
            `SVP_ADR_SET: d.dat = {16'h0000, q.set[wsel[1:0]]};
            `SVP_ADR_BLK: d.dat = {16'h0000, q.blk[wsel[1:0]]};
            `SVP_ADR_DLY: d.dat = {16'h0000, q.dly[wsel[1:0]]};
            `SVP_ADR_REL: d.dat = {16'h0000, q.rel[wsel[1:0]]};
            `SVP_ADR_STAT: d.dat = {10'h000, q.start, q.st[wsel[1:0]], q.blocked, q.over,
                                    q.drel, q.trip};
            `SVP_ADR_MAG: d.dat = {16'h0000, q.mag};
            `SVP_ADR_RATIO: d.dat = {16'h0000, q.ratio[wsel[1:0]]};
            `SVP_ADR_TIME: d.dat = {q.cnt[wsel[1:0]], q.dly[wsel[1:0]]};
            default: d.dat = 32'h0000_0000;
         endcase
      end
      // Writes land at the edge that samples ack high, with the request still held
      if (wb_cyc_i && wb_stb_i && wb_we_i && q.ack)
      begin
            case (wb_adr_i & 8'h3C)
               // Static settings change only here, never through groups
               `SVP_ADR_CTRL: d.ctrl = {16'h0000, bmerge(q.ctrl[15:0], wb_dat_i, wb_sel_i)};
               `SVP_ADR_SET: d.set[wsel[1:0]] = bmerge(q.set[wsel[1:0]], wb_dat_i, wb_sel_i);
               `SVP_ADR_BLK: d.blk[wsel[1:0]] = bmerge(q.blk[wsel[1:0]], wb_dat_i, wb_sel_i);
               `SVP_ADR_DLY: d.dly[wsel[1:0]] = bmerge(q.dly[wsel[1:0]], wb_dat_i, wb_sel_i);
               `SVP_ADR_REL: d.rel[wsel[1:0]] = bmerge(q.rel[wsel[1:0]], wb_dat_i, wb_sel_i);
               `SVP_ADR_STAT:
               begin
                  if (wb_sel_i[1])
                  begin
                     d.over[wsel[1:0]] = wb_dat_i[11];
                     d.drel[wsel[1:0]] = wb_dat_i[7];
                  end
               end
               default: d.calc = q.calc;
            endcase
      end
      // Evaluate all stages once per program cycle
      if (cycle_tick)
      begin
         d.mag = lvl_mag;
         d.ext_blk = block_in;
         for (int i = 0; i < 4; i++)
         begin
            // Ratio in hundredths of the level
            d.ratio[i] = (q.set[i] == 16'h0000) ? 16'hFFFF :
                         16'((32'(lvl_mag) * 32'd100) / 32'(q.set[i]));
            prod = 32'(lvl_mag) * 32'd100;
            hyst = 32'(q.set[i]) * (q.over[i] ? 32'(`SVP_HYST_OVER) : 32'(`SVP_HYST_UNDER));
            if (q.over[i])
               pick_n = q.pick[i] ? (prod >= hyst) : (lvl_mag > q.set[i]);
            else
               pick_n = q.pick[i] ? (prod <= hyst) : (lvl_mag < q.set[i]);
            // Low-voltage latch: zero level disables it
            lowblk_n = q.lowblk[i];
            if (q.over[i] || q.blk[i] == 16'h0000)
               lowblk_n = 1'b0;
            else if (lvl_mag < q.blk[i])
               lowblk_n = 1'b1;
            else if (line_mag1 > q.set[i] && line_mag2 > q.set[i] && line_mag3 > q.set[i])
               lowblk_n = 1'b0;
            d.pick[i] = pick_n;
            d.lowblk[i] = lowblk_n;
            d.trip[i] = 1'b0;
            case (q.st[i])
               svp_pkg::SVP_S_IDLE:
               begin
                  d.cnt[i] = 16'h0000;
                  if (pick_n && block_in[i])
                     d.st[i] = svp_pkg::SVP_S_BLK;
                  else if (pick_n)
                  begin
                     d.st[i] = svp_pkg::SVP_S_RUN;
                     trip_n = (q.dly[i] == 16'h0000) && !lowblk_n;
                     d.trip[i] = trip_n;
                  end
               end
               svp_pkg::SVP_S_RUN:
               begin
                  if (!pick_n || block_in[i])
                  begin
                     // Block during START handled as a dropout
                     d.rcnt[i] = 16'h0000;
                     d.st[i] = q.drel[i] ? svp_pkg::SVP_S_HOLD : svp_pkg::SVP_S_IDLE;
                     if (block_in[i])
                        d.st[i] = q.drel[i] ? svp_pkg::SVP_S_HOLD : svp_pkg::SVP_S_BLK;
                  end
                  else
                  begin
                     if (q.cnt[i] < q.dly[i])
                        d.cnt[i] = 16'(q.cnt[i] + 16'h0001);
                     trip_n = (16'(q.cnt[i] + 16'h0001) >= q.dly[i]) && !lowblk_n;
                     d.trip[i] = trip_n;
                  end
               end
               svp_pkg::SVP_S_HOLD:
               begin
                  d.rcnt[i] = 16'(q.rcnt[i] + 16'h0001);
                  if (pick_n && !block_in[i])
                     d.st[i] = svp_pkg::SVP_S_RUN;
                  else if (16'(q.rcnt[i] + 16'h0001) >= q.rel[i])
                  begin
                     d.st[i] = block_in[i] ? svp_pkg::SVP_S_BLK : svp_pkg::SVP_S_IDLE;
                     d.cnt[i] = 16'h0000;
                  end
               end
               svp_pkg::SVP_S_BLK:
               begin
                  if (!block_in[i])
                     d.st[i] = svp_pkg::SVP_S_IDLE;
               end
               default: d.st[i] = svp_pkg::SVP_S_IDLE;
            endcase
            d.start[i] = (d.st[i] == svp_pkg::SVP_S_RUN) || (d.st[i] == svp_pkg::SVP_S_HOLD);
            d.blocked[i] = (d.st[i] == svp_pkg::SVP_S_BLK);
            // Forcing overrides the status only when globally allowed
            if (force_enable)
            begin
               case (svp_pkg::svp_force_t'(q.ctrl[9:8]))
                  svp_pkg::SVP_F_START:
                  begin
                     d.start[i] = 1'b1;
                     d.trip[i] = 1'b0;
                     d.blocked[i] = 1'b0;
                  end
                  svp_pkg::SVP_F_TRIP:
                  begin
                     d.start[i] = 1'b1;
                     d.trip[i] = 1'b1;
                     d.blocked[i] = 1'b0;
                  end
                  svp_pkg::SVP_F_BLOCKED:
                  begin
                     d.start[i] = 1'b0;
                     d.trip[i] = 1'b0;
                     d.blocked[i] = 1'b1;
                  end
                  default: d.calc = q.calc;
               endcase
            end
         end
      end
   end

   // ==========================================================
   // State register; reset loads constants only
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= '0;
         q.ctrl <= `SVP_CTRL_RST;
         q.set <= {4{`SVP_SET_DEF}};
         q.blk <= {4{`SVP_BLK_DEF}};
         q.dly <= {4{`SVP_DLY_DEF}};
         q.rel <= {4{`SVP_REL_DEF}};
         q.over <= 4'hF;
         q.drel <= 4'hF;
      end
      else if (!rst_n_int)
      begin
         q <= '0;
         q.rst_sync <= d.rst_sync;
         q.ctrl <= `SVP_CTRL_RST;
         q.set <= {4{`SVP_SET_DEF}};
         q.blk <= {4{`SVP_BLK_DEF}};
         q.dly <= {4{`SVP_DLY_DEF}};
         q.rel <= {4{`SVP_REL_DEF}};
         q.over <= 4'hF;
         q.drel <= 4'hF;
      end
      else
      begin
         q <= d;
      end
   end

   assign wb_dat_o = q.dat;
   assign wb_ack_o = q.ack;
   assign start_o = q.start;
   assign trip_o = q.trip;
   assign blocked_o = q.blocked;

   // ==========================================================
   // Checks
   sequence s_blocked_pick;
      cycle_tick && q.st[0] == svp_pkg::SVP_S_IDLE && block_in[0] && d.pick[0];
   endsequence
   trip_gate_a: assert property (@(posedge clk) disable iff (!rst_n_int)
      (trip_o[0] && !force_enable) |-> (start_o[0] && !blocked_o[0]))
      else $error("trip without start");
   ack_one_a: assert property (@(posedge clk) disable iff (!rst_n_int)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");
   blk_pick_a: assert property (@(posedge clk) disable iff (!rst_n_int)
      (s_blocked_pick and !force_enable) |=> (blocked_o[0] && !start_o[0]))
      else $error("blocked pickup started");
   blk_clear_a: assert property (@(posedge clk) disable iff (!rst_n_int)
      (cycle_tick && q.st[0] == svp_pkg::SVP_S_RUN && block_in[0] && !q.drel[0]
       && !force_enable) |=> !start_o[0])
      else $error("start kept under block");
   low_dis_a: assert property (@(posedge clk) disable iff (!rst_n_int)
      (cycle_tick && q.blk[0] == 16'h0000) |=> !q.lowblk[0])
      else $error("block latch with zero level");
   ack_time_a: assert property (@(posedge clk) disable iff (!rst_n_int)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("no ack");
   start_pick_a: assert property (@(posedge clk) disable iff (!rst_n_int)
      (cycle_tick && q.st[0] == svp_pkg::SVP_S_IDLE && !block_in[0] && d.pick[0]
       && !force_enable) |=> start_o[0])
      else $error("no start on pickup");
   force_trip_a: assert property (@(posedge clk) disable iff (!rst_n_int)
      (cycle_tick && force_enable && q.ctrl[9:8] == 2'b10) |=> trip_o[0])
      else $error("forced trip missing");
endmodule
`default_nettype wire

// ==== dv/svp_front_model.sv ====
// Behavioural measurement front end feeding the protection stage.
// Assumes the bench sets the wanted magnitude and phase order between ticks.
`timescale 1ns/1ps
`default_nettype none
module svp_front_model
#(
   parameter int TICK_CYC = 40
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [15:0] mag,
   input wire logic rev_order,
   output logic cycle_tick,
   output logic signed [17:0] l1_re,
   output logic signed [17:0] l1_im,
   output logic signed [17:0] l2_re,
   output logic signed [17:0] l2_im,
   output logic signed [17:0] l3_re,
   output logic signed [17:0] l3_im,
   output logic [15:0] line_mag
);
   int cnt;
   logic [15:0] mag_q;
   logic rev_q;
   logic signed [17:0] h;
   logic signed [17:0] k;
   // Program cycle shortened to TICK_CYC clocks; values refresh only at the tick
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt <= 0;
         cycle_tick <= 1'b0;
         mag_q <= 16'h0000;
         rev_q <= 1'b0;
      end
      else
      begin
         cnt <= (cnt == TICK_CYC - 1) ? 0 : cnt + 1;
         cycle_tick <= (cnt == 0);
         if (cnt == 0)
         begin
            mag_q <= mag;
            rev_q <= rev_order;
         end
      end
   end
   // Balanced set with L1 on the real axis, so the sequence result has no imaginary part
   assign h = {3'b000, mag_q[15:1]};
   assign k = 18'((32'(mag_q) * 28378) >> 15);
   assign l1_re = {2'b00, mag_q};
   assign l1_im = 18'sh00000;
   assign l2_re = -h;
   assign l3_re = -h;
   assign l2_im = rev_q ? k : -k;
   assign l3_im = rev_q ? -k : k;
   assign line_mag = 16'((32'(mag_q) * 10000) >> 15);
endmodule
`default_nettype wire

// ==== dv/svp_stage_test.sv ====
// Self-checking bench for the four-stage sequence voltage protection.
// Assumes the front end model strobes a program cycle every 40 clocks.
`timescale 1ns/1ps
`include "svp_consts.svh"
`default_nettype none
module svp_stage_test;
   logic clk;
   logic rst_n;
   logic [15:0] mag;
   logic rev_order;
   logic cycle_tick;
   logic signed [17:0] l1_re, l1_im, l2_re, l2_im, l3_re, l3_im;
   logic [15:0] line_mag;
   logic [3:0] block_in;
   logic force_enable;
   logic wb_cyc, wb_stb, wb_we, wb_ack;
   logic [7:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_dat_w, wb_dat_r, rd;
   logic [3:0] start_o, trip_o, blocked_o;
   logic exp_st;
   int err_count;
   int checks;
   int seed;
   int p;
   svp_front_model i_front (.clk, .rst_n, .mag, .rev_order, .cycle_tick, .l1_re, .l1_im,
      .l2_re, .l2_im, .l3_re, .l3_im, .line_mag);
   svp_stage i_dut (.clk, .rst_n, .cycle_tick, .l1_re, .l1_im, .l2_re, .l2_im, .l3_re,
      .l3_im, .line_mag1(line_mag), .line_mag2(line_mag), .line_mag3(line_mag), .block_in,
      .force_enable, .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
      .start_o, .trip_o, .blocked_o);
   // ==========================================================
   // Helpers
   task automatic summarize();
      if (err_count == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic hang();
      err_count++;
      $display("[ERR] %0t wait ran out", $time);
      summarize();
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Classic single Wishbone cycle; the request stands until ack is sampled
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int n;
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_dat_w <= dat;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wb_ack !== 1'b1 && n < 20);
      rd = wb_dat_r;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      if (n >= 20)
         hang();
   endtask
   // Waits for n program cycles, then lets the stage outputs settle
   task automatic ticks(input int n);
      int c;
      repeat (n)
      begin
         c = 0;
         do
         begin
            @(posedge clk);
            c++;
         end
         while (cycle_tick !== 1'b1 && c < 100);
         if (c >= 100)
            hang();
      end
      repeat (3) @(posedge clk);
   endtask
   task automatic set(input int pct);
      mag <= 16'(pct * 32768 / 100);
   endtask
   // Pick-up state with the fixed 97 and 103 percent release points, level in 0.01 percent
   function automatic logic nxt_start(logic prev, int pct, int lvl, logic over);
      if (over)
         return (pct * 100 > lvl) ? 1'b1 : ((pct * 10000 < lvl * 97) ? 1'b0 : prev);
      return (pct * 100 < lvl) ? 1'b1 : ((pct * 10000 > lvl * 103) ? 1'b0 : prev);
   endfunction
   // ==========================================================
   // Clock
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ==========================================================
   // Main sequence
   initial
   begin
      {rst_n, mag, rev_order, block_in, force_enable} = '0;
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w} = '0;
      wb_sel = 4'h3;
      {err_count, checks, exp_st} = '0;
      seed = 65;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      // Defaults, then park stages 1 to 3 out of reach to show independence
      for (int s = 0; s < 4; s++)
      begin
         wb(1'b0, 8'(s * 64) + `SVP_ADR_SET, 0); chk(rd, 32'h0000_2904);
         wb(1'b0, 8'(s * 64) + `SVP_ADR_BLK, 0); chk(rd, 32'h0000_01F4);
         wb(1'b0, 8'(s * 64) + `SVP_ADR_DLY, 0); chk(rd, 32'h0000_0008);
         wb(1'b0, 8'(s * 64) + `SVP_ADR_REL, 0); chk(rd, 32'h0000_000C);
         wb(1'b0, 8'(s * 64) + `SVP_ADR_CTRL, 0); chk(rd & 32'h1, 32'h0);
         if (s > 0)
            wb(1'b1, 8'(s * 64) + `SVP_ADR_SET, 32'h0000_3A98);
      end
      wb(1'b0, 8'h3C, 0); chk(rd, 32'h0);
      wb(1'b1, `SVP_ADR_STAT, 32'h0000_0800);
      // Over pick-up, fixed delay and hysteresis
      set(120); ticks(1); chk(start_o, 4'h1); chk(trip_o, 4'h0);
      wb(1'b0, `SVP_ADR_RATIO, 0); chk(32'(rd >= 113 && rd <= 115), 32'h1);
      ticks(6); chk(trip_o, 4'h0);
      wb(1'b0, `SVP_ADR_TIME, 0); chk(rd, 32'h0006_0008);
      ticks(3); chk(trip_o, 4'h1);
      set(104); ticks(1); chk(start_o, 4'h1);
      set(100); ticks(1); chk({start_o, trip_o}, 8'h00);
      // Zero delay trips together with start
      wb(1'b1, `SVP_ADR_DLY, 0);
      set(120); ticks(1); chk(trip_o, 4'h1);
      set(100); ticks(1);
      wb(1'b1, `SVP_ADR_DLY, 32'h8);
      // Block before pick-up, then block arriving during start
      block_in <= 4'h1;
      set(120); ticks(1); chk({start_o, blocked_o}, 8'h01);
      block_in <= 4'h0; set(100); ticks(2);
      set(120); ticks(2); chk(start_o, 4'h1);
      block_in <= 4'h1;
      ticks(1); chk({start_o, trip_o}, 8'h00);
      block_in <= 4'h0; set(100); ticks(2);
      // Delayed release holds start for two cycles
      wb(1'b1, `SVP_ADR_REL, 32'h2); wb(1'b1, `SVP_ADR_STAT, 32'h0000_0880);
      set(120); ticks(1); set(100); ticks(1); chk(start_o, 4'h1);
      ticks(3); chk(start_o, 4'h0);
      // Under mode at 90 percent, low-voltage latch and its disable
      wb(1'b1, `SVP_ADR_SET, 32'h0000_2328); wb(1'b1, `SVP_ADR_STAT, 32'h0);
      set(95); ticks(2); chk(start_o, 4'h0);
      set(85); ticks(1); chk(start_o, 4'h1);
      set(92); ticks(1); chk(start_o, 4'h1);
      set(95); ticks(1); chk(start_o, 4'h0);
      set(2); ticks(10); chk(trip_o, 4'h0);
      set(85); ticks(2); chk(trip_o, 4'h0);
      wb(1'b1, `SVP_ADR_BLK, 0); set(95); ticks(2);
      set(2); ticks(10); chk(trip_o, 4'h1);
      set(100); ticks(2);
      wb(1'b1, `SVP_ADR_SET, 32'h2904); wb(1'b1, `SVP_ADR_BLK, 32'h1F4);
      wb(1'b1, `SVP_ADR_STAT, 32'h0800);
      // Sequence selection against phase order
      rev_order <= 1'b1; set(120); ticks(2); chk(start_o, 4'h0);
      wb(1'b1, `SVP_ADR_CTRL, 32'h3); ticks(2); chk(start_o, 4'h1);
      rev_order <= 1'b0; ticks(2); chk(start_o, 4'h0);
      set(100); wb(1'b1, `SVP_ADR_CTRL, 32'h2); ticks(2);
      // Every forced status, then forcing switched off
      force_enable <= 1'b1;
      for (int f = 1; f < 4; f++)
      begin
         wb(1'b1, `SVP_ADR_CTRL, 32'h2 | (f << 8)); ticks(1);
         chk({start_o[0], trip_o[0], blocked_o[0]},
             (f == 3) ? 3'b001 : ((f == 2) ? 3'b110 : 3'b100));
      end
      wb(1'b1, `SVP_ADR_CTRL, 32'h202); force_enable <= 1'b0;
      ticks(1); chk(trip_o, 4'h0);
      wb(1'b1, `SVP_ADR_CTRL, 32'h2); ticks(1);
      // Random magnitudes well clear of the thresholds
      for (int i = 0; i < 40; i++)
      begin
         p = ($random(seed) & 1) ? 115 + ($random(seed) & 15) : 80 + ($random(seed) & 15);
         set(p); ticks(1);
         exp_st = nxt_start(exp_st, p, 10500, 1'b1);
         chk(start_o, {3'b000, exp_st});
         chk(trip_o & ~start_o, 4'h0);
      end
      summarize();
   end
endmodule
`default_nettype wire
